/* File: include/coil_ctrl_regs.svh */
// Constants for the coil select and inverter voltage controller.
// Assumes a 20 MHz clk and voltages and currents in mV and mA.
`ifndef COIL_CTRL_REGS_SVH
`define COIL_CTRL_REGS_SVH

// -----------------------------------------------------------------
// Register offsets and fields
// -----------------------------------------------------------------
`define REG_CTRL        8'h00
`define REG_COIL_REQ    8'h04
`define REG_COIL_STAT   8'h08
`define REG_TARGET      8'h0c
`define REG_MEAS        8'h10
`define REG_VOLT        8'h14
`define REG_PERIOD      8'h18
`define CTRL_PWR_BIT    0
`define STAT_BAD_BIT    8
`define COIL_RST        6'h01
`define PERIOD_RST      8'hb5

// -----------------------------------------------------------------
// Coil overlap rows, self bit included
// -----------------------------------------------------------------
`define OVL_ROW0        6'h1d
`define OVL_ROW1        6'h3e
`define OVL_ROW2        6'h37
`define OVL_ROW3        6'h2a
`define OVL_ROW4        6'h37
`define OVL_ROW5        6'h3a

// -----------------------------------------------------------------
// Voltage, current and loop figures
// -----------------------------------------------------------------
`define V_MAX_MV        15'd20000
`define V_PING_MV       15'd12000
`define I_LIM_MULTI_MA  16'd4000
`define I_LIM_SINGLE_MA 16'd2000
`define PROP_GAIN       18'sd1
`define LOOP_CAP        18'sd2000
`define VOLT_SCALE_MV   (-18'sd1)

// -----------------------------------------------------------------
// Drive frequency as clock counts
// -----------------------------------------------------------------
`define CLK_KHZ         20000
`define FOP_MIN_KHZ     105
`define FOP_MAX_KHZ     113
`define PERIOD_MAX      8'(`CLK_KHZ / `FOP_MIN_KHZ)
`define PERIOD_MIN      8'((`CLK_KHZ + `FOP_MAX_KHZ - 1) / `FOP_MAX_KHZ)

`endif

/* File: include/coil_ctrl_pkg.sv */
// Types shared by the coil select and voltage controller.
// Assumes the constants header is included by the user files.
package coil_ctrl_pkg;
	typedef logic [5:0]  coil_mask_t;
	typedef logic [14:0] volt_mv_t;
	typedef logic [15:0] cur_ma_t;
	typedef logic [7:0]  period_t;
	typedef enum logic [2:0] {
		PS_OFF  = 3'b001,
		PS_PING = 3'b010,
		PS_REG  = 3'b100
	} pwr_state_t;
endpackage : coil_ctrl_pkg

/* File: include/drive_if.sv */
// Link between the controller and the half-bridge drive generator.
// Assumes both ends share clk.
`timescale 1ns/100ps
`default_nettype none
interface drive_if;
	logic    run;
	logic [7:0] period;
	logic    hb_high;
	logic    hb_low;
	modport ctrl (output run, output period, input hb_high, input hb_low);
	modport gen  (input run, input period, output hb_high, output hb_low);
endinterface : drive_if
`default_nettype wire

/* File: verilog/coil_set_check.sv */
// Checks a requested coil mask: size one to three and full mutual overlap.
// Assumes the overlap rows of the constants header.
`include "coil_ctrl_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module coil_set_check (
	// Request
	input  wire coil_ctrl_pkg::coil_mask_t mask,
	// Verdict
	output logic [1:0]                     count,
	output logic                           ok
);
	import coil_ctrl_pkg::*;

	function automatic coil_mask_t ovl_row(input int idx);
		case (idx)
			0:       ovl_row = `OVL_ROW0;
			1:       ovl_row = `OVL_ROW1;
			2:       ovl_row = `OVL_ROW2;
			3:       ovl_row = `OVL_ROW3;
			4:       ovl_row = `OVL_ROW4;
			default: ovl_row = `OVL_ROW5;
		endcase
	endfunction : ovl_row

	// A chosen coil may only sit with coils it overlaps
	logic [5:0] bad_bit;
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_ovl
			assign bad_bit[gi] = mask[gi] && |(mask & ~ovl_row(gi));
		end
	endgenerate

	wire [2:0] pop = 3'(mask[0]) + 3'(mask[1]) + 3'(mask[2])
		+ 3'(mask[3]) + 3'(mask[4]) + 3'(mask[5]);
	assign count = pop[1:0];
	assign ok    = (pop != 3'd0) && (pop <= 3'd3) && !(|bad_bit);
endmodule : coil_set_check
`default_nettype wire

/* File: verilog/hb_drive_gen.sv */
// Half-bridge gate drive with 50% duty at a period given in clocks.
// Assumes the period is already held inside the legal band.
`timescale 1ns/100ps
`default_nettype none
module hb_drive_gen (
	// Clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// Controller side
	drive_if.gen      drv
);
	logic [7:0] cnt_q;
	logic       high_q;
	logic       low_q;
	wire        wrap = (cnt_q >= drv.period - 8'd1);
	wire        first_half = (cnt_q < {1'b0, drv.period[7:1]});

	// Counter wraps every period, so f = clk / period
	always_ff @(posedge clk) begin
		if (srst || !drv.run || wrap) begin
			cnt_q <= 8'h00;
		end else begin
			cnt_q <= cnt_q + 8'd1;
		end
	end

	// Registered gates, both low while stopped
	always_ff @(posedge clk) begin
		if (srst) begin
			high_q <= 1'b0;
			low_q  <= 1'b0;
		end else begin
			high_q <= drv.run && first_half;
			low_q  <= drv.run && !first_half;
		end
	end

	assign drv.hb_high = high_q;
	assign drv.hb_low  = low_q;
endmodule : hb_drive_gen
`default_nettype wire

/* File: verilog/coil_select_voltage_pid_ctrl.sv */
// Top of the coil select and inverter voltage controller.
// Assumes current samples arrive on clk, one mA per LSB, as RMS values.
`include "coil_ctrl_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module coil_select_voltage_pid_ctrl (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    srst,
	// Register port
	input  wire logic [7:0]              addr,
	input  wire logic [31:0]             wdata,
	input  wire logic                    wr,
	input  wire logic                    rd,
	output logic [31:0]                  rdata,
	// Cell current samples
	input  wire coil_ctrl_pkg::cur_ma_t  cell_cur_ma,
	input  wire logic                    cell_cur_vld,
	// Power stage controls
	output coil_ctrl_pkg::coil_mask_t    coil_en,
	output logic                         match_sw_close,
	output coil_ctrl_pkg::volt_mv_t      vin_cmd_mv,
	output logic                         hb_high,
	output logic                         hb_low
);
	import coil_ctrl_pkg::*;

	// -----------------------------------------------------------------
	// Register decode
	// -----------------------------------------------------------------
	wire wr_ctrl   = wr && (addr == `REG_CTRL);
	wire wr_coil   = wr && (addr == `REG_COIL_REQ);
	wire wr_stat   = wr && (addr == `REG_COIL_STAT);
	wire wr_target = wr && (addr == `REG_TARGET);
	wire wr_period = wr && (addr == `REG_PERIOD);

	logic       pwr_en_q;
	coil_mask_t coil_req_q;
	coil_mask_t coil_act_q;
	logic       sw_q;
	logic       bad_q;
	cur_ma_t    target_q;
	cur_ma_t    meas_q;
	volt_mv_t   volt_q;
	volt_mv_t   ceil_q;
	period_t    period_q;
	logic [31:0] rdata_q;
	pwr_state_t state_q;
	pwr_state_t state_d;

	// -----------------------------------------------------------------
	// Coil set validation
	// -----------------------------------------------------------------
	logic [1:0] req_cnt;
	logic       req_ok;
	coil_set_check u_req_check (
		.mask  (wdata[5:0]),
		.count (req_cnt),
		.ok    (req_ok)
	);
	wire take_coil = wr_coil && req_ok;
	wire bad_set   = wr_coil && !req_ok;
	wire multi_req = (req_cnt >= 2'd2);

	// A rejected set leaves the old cell in place, so never zero coils
	always_ff @(posedge clk) begin
		if (srst) begin
			coil_act_q <= `COIL_RST;
			sw_q       <= 1'b0;
		end else if (take_coil) begin
			coil_act_q <= wdata[5:0];
			sw_q       <= multi_req;
		end
	end

	// Last request kept for readback
	always_ff @(posedge clk) begin
		if (srst) begin
			coil_req_q <= `COIL_RST;
		end else if (wr_coil) begin
			coil_req_q <= wdata[5:0];
		end
	end

	// Sticky bad-request flag, write one to clear; a new bad set wins
	wire bad_clr = wr_stat && wdata[`STAT_BAD_BIT];
	always_ff @(posedge clk) begin
		if (srst) begin
			bad_q <= 1'b0;
		end else begin
			bad_q <= bad_set || (bad_q && !bad_clr);
		end
	end

	// -----------------------------------------------------------------
	// Software settings
	// -----------------------------------------------------------------
	// Period clamped into the legal drive band on write
	wire [7:0] per_w  = wdata[7:0];
	wire [7:0] per_lo = (per_w < `PERIOD_MIN) ? `PERIOD_MIN : per_w;
	wire [7:0] per_cl = (per_lo > `PERIOD_MAX) ? `PERIOD_MAX : per_lo;

	always_ff @(posedge clk) begin
		if (srst) begin
			pwr_en_q <= 1'b0;
			target_q <= 16'h0000;
			period_q <= `PERIOD_RST;
		end else begin
			if (wr_ctrl) begin
				pwr_en_q <= wdata[`CTRL_PWR_BIT];
			end
			if (wr_target) begin
				target_q <= wdata[15:0];
			end
			if (wr_period) begin
				period_q <= per_cl;
			end
		end
	end

	// -----------------------------------------------------------------
	// Current measurement
	// -----------------------------------------------------------------
	// Full 1 mA resolution is kept, well inside 5 mA
	always_ff @(posedge clk) begin
		if (srst) begin
			meas_q <= 16'h0000;
		end else if (cell_cur_vld) begin
			meas_q <= cell_cur_ma;
		end
	end

	// -----------------------------------------------------------------
	// Power state
	// -----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
			PS_OFF: begin
				if (pwr_en_q) begin
					state_d = PS_PING;
				end
			end
			PS_PING: begin
				if (!pwr_en_q) begin
					state_d = PS_OFF;
				end else if (cell_cur_vld) begin
					state_d = PS_REG;
				end
			end
			PS_REG: begin
				if (!pwr_en_q) begin
					state_d = PS_OFF;
				end
			end
			default: begin
				state_d = PS_OFF;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_q <= PS_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	// -----------------------------------------------------------------
	// Current cap and voltage ceiling
	// -----------------------------------------------------------------
	// Limit follows the cell actually connected
	wire     multi   = sw_q;
	wire     loop_go = (state_q == PS_REG) && cell_cur_vld;
	cur_ma_t i_lim;
	assign i_lim = multi ? `I_LIM_MULTI_MA : `I_LIM_SINGLE_MA;
	wire     over    = cell_cur_ma > i_lim;
	cur_ma_t excess;
	assign excess = cell_cur_ma - i_lim;

	// Overshoot sets the ceiling one mV per mA over below the present voltage
	wire signed [17:0] ceil_red = $signed({3'b000, volt_q})
		- $signed({2'b00, excess});
	volt_mv_t ceil_cut;
	assign ceil_cut = ceil_red[17] ? 15'd0 : ceil_red[14:0];
	volt_mv_t ceil_now;
	assign ceil_now = (loop_go && over) ? ceil_cut : ceil_q;

	// Ceiling reopens when power or the cell changes
	always_ff @(posedge clk) begin
		if (srst || take_coil || (state_q == PS_OFF)) begin
			ceil_q <= `V_MAX_MV;
		end else begin
			ceil_q <= ceil_now;
		end
	end

	// -----------------------------------------------------------------
	// Proportional loop
	// -----------------------------------------------------------------
	// Error is measured minus target, so excess current lowers voltage
	wire signed [16:0] err = $signed({1'b0, cell_cur_ma})
		- $signed({1'b0, target_q});
	wire signed [17:0] p_term = 18'(err) * `PROP_GAIN;
	// Integral and derivative gains are zero, so those terms drop out
	wire signed [17:0] pid_out = (p_term > `LOOP_CAP) ? `LOOP_CAP :
		(p_term < -`LOOP_CAP) ? -`LOOP_CAP : p_term;
	wire signed [17:0] dv = pid_out * `VOLT_SCALE_MV;
	wire signed [17:0] v_raw = $signed({3'b000, volt_q}) + dv;
	wire signed [17:0] v_top = $signed({3'b000, ceil_now});

	// Saturate to ceiling and zero; ceiling never exceeds 20 V
	volt_mv_t v_sat;
	assign v_sat = v_raw[17] ? 15'd0 :
		(v_raw > v_top) ? ceil_now : v_raw[14:0];

	volt_mv_t volt_d;
	always_comb begin
		volt_d = volt_q;
		case (state_q)
			PS_OFF: begin
				volt_d = pwr_en_q ? `V_PING_MV : 15'd0;
			end
			PS_PING: begin
				volt_d = pwr_en_q ? volt_q : 15'd0;
			end
			PS_REG: begin
				if (!pwr_en_q) begin
					volt_d = 15'd0;
				end else if (loop_go) begin
					volt_d = v_sat;
				end
			end
			default: begin
				volt_d = 15'd0;
			end
		endcase
	end

	// One mV per LSB, so steps are far finer than 35 mV
	always_ff @(posedge clk) begin
		if (srst) begin
			volt_q <= 15'd0;
		end else begin
			volt_q <= volt_d;
		end
	end

	// -----------------------------------------------------------------
	// Inverter drive
	// -----------------------------------------------------------------
	drive_if drv ();
	assign drv.run    = (state_q != PS_OFF);
	assign drv.period = period_q;
	hb_drive_gen u_drive (
		.clk  (clk),
		.srst (srst),
		.drv  (drv)
	);

	// -----------------------------------------------------------------
	// Readback
	// -----------------------------------------------------------------
	logic [31:0] rd_mux;
	always_comb begin
		case (addr)
			`REG_CTRL:      rd_mux = {31'h0, pwr_en_q};
			`REG_COIL_REQ:  rd_mux = {26'h0, coil_req_q};
			`REG_COIL_STAT: rd_mux = {23'h0, bad_q, 2'h0, coil_act_q};
			`REG_TARGET:    rd_mux = {16'h0, target_q};
			`REG_MEAS:      rd_mux = {16'h0, meas_q};
			`REG_VOLT:      rd_mux = {1'b0, ceil_q, 1'b0, volt_q};
			`REG_PERIOD:    rd_mux = {24'h0, period_q};
			default:        rd_mux = 32'h0;
		endcase
	end

	// Data valid only in the cycle after the read strobe
	always_ff @(posedge clk) begin
		if (srst || !rd) begin
			rdata_q <= 32'h0;
		end else begin
			rdata_q <= rd_mux;
		end
	end

	assign rdata          = rdata_q;
	assign coil_en        = coil_act_q;
	assign match_sw_close = sw_q;
	assign vin_cmd_mv     = volt_q;
	assign hb_high        = drv.hb_high;
	assign hb_low         = drv.hb_low;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	logic [2:0] act_cnt;
	logic       act_ok;
	assign act_cnt = 3'(coil_act_q[0]) + 3'(coil_act_q[1])
		+ 3'(coil_act_q[2]) + 3'(coil_act_q[3])
		+ 3'(coil_act_q[4]) + 3'(coil_act_q[5]);
	assign act_ok = (act_cnt != 3'd0) && (act_cnt <= 3'd3);

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_ping_start;
		(state_q == PS_OFF) && pwr_en_q;
	endsequence
	sequence s_over_step;
		loop_go && over;
	endsequence

	AST_COIL_COUNT: assert property (act_ok && act_cnt != 3'd0)
		else $error("coil cell not one to three coils");
	AST_COIL_TAKE: assert property ($changed(coil_act_q) |-> $past(req_ok && wr_coil) || $past(srst))
		else $error("coil cell changed without a valid set");
	AST_SWITCH: assert property (sw_q == (act_cnt >= 3'd2))
		else $error("matching switch disagrees with coil count");
	AST_VMAX: assert property (volt_q <= `V_MAX_MV)
		else $error("voltage above 20 V");
	AST_PING: assert property (s_ping_start |=> volt_q == `V_PING_MV)
		else $error("ping did not start at 12 V");
	AST_STEP: assert property (loop_go && pwr_en_q && !over |=> (volt_q <= $past(volt_q) + 15'd2000)
		&& (volt_q + 15'd2000 >= $past(volt_q)))
		else $error("loop step above output cap");
	AST_LIMIT: assert property (s_over_step |=> volt_q < $past(volt_q) || volt_q == 15'd0)
		else $error("over-current did not lower voltage");
	AST_CEIL: assert property (state_q == PS_REG |-> volt_q <= ceil_q)
		else $error("voltage above ceiling");
	AST_MEAS: assert property (cell_cur_vld |=> meas_q == $past(cell_cur_ma))
		else $error("measured current not reported");
	AST_FREQ: assert property (period_q >= `PERIOD_MIN && period_q <= `PERIOD_MAX)
		else $error("drive period out of band");
	AST_HOLD: assert property (state_q == PS_REG && !cell_cur_vld && pwr_en_q
		|=> $stable(volt_q))
		else $error("voltage moved without a loop update");
endmodule : coil_select_voltage_pid_ctrl
`default_nettype wire

/* File: dv/rx_cell_model.sv */
// Receiver side model: returns cell current samples on request.
// Assumes the bench asks for each sample and shares clk with the controller.
`timescale 1ns/100ps
`default_nettype none
module rx_cell_model (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   srst,
	// Sample request from the bench
	input  wire logic                   send,
	input  wire coil_ctrl_pkg::cur_ma_t send_ma,
	input  wire logic [3:0]             lag,
	// Current sense towards the controller
	output coil_ctrl_pkg::cur_ma_t      cell_cur_ma,
	output logic                        cell_cur_vld
);
	import coil_ctrl_pkg::*;
	logic [3:0] cnt_q;
	cur_ma_t    val_q;
	logic       pend_q;

	// Sample path; data toggles between pulses so a stale value never looks valid
	always_ff @(posedge clk) begin
		if (srst) begin
			pend_q       <= 1'b0;
			cnt_q        <= 4'h0;
			val_q        <= 16'h0000;
			cell_cur_vld <= 1'b0;
			cell_cur_ma  <= 16'hffff;
		end else begin
			cell_cur_vld <= 1'b0;
			cell_cur_ma  <= ~cell_cur_ma;
			if (send) begin
				pend_q <= 1'b1;
				cnt_q  <= lag;
				val_q  <= send_ma;
			end else if (pend_q && cnt_q == 4'h0) begin
				pend_q       <= 1'b0;
				cell_cur_vld <= 1'b1;
				cell_cur_ma  <= val_q;
			end else if (pend_q) begin
				cnt_q <= cnt_q - 4'h1;
			end
		end
	end
endmodule : rx_cell_model
`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking bench for the coil select and inverter voltage controller.
// Assumes the constants header and package are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "coil_ctrl_regs.svh"
module testbench;
	import coil_ctrl_pkg::*;
	logic        clk, srst, wr, rd, send, cell_cur_vld;
	logic        match_sw_close, hb_high, hb_low;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  lag;
	cur_ma_t     send_ma, cell_cur_ma;
	coil_mask_t  coil_en;
	volt_mv_t    vin_cmd_mv;
	int          error_cnt, num_checks;

	// ---------------------------------------------------------------
	// Instances
	// ---------------------------------------------------------------
	coil_select_voltage_pid_ctrl u_dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .cell_cur_ma(cell_cur_ma), .cell_cur_vld(cell_cur_vld), .coil_en(coil_en),
		.match_sw_close(match_sw_close), .vin_cmd_mv(vin_cmd_mv), .hb_high(hb_high), .hb_low(hb_low));
	rx_cell_model u_rx (.clk(clk), .srst(srst), .send(send), .send_ma(send_ma), .lag(lag),
		.cell_cur_ma(cell_cur_ma), .cell_cur_vld(cell_cur_vld));

	// 50 ns clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t %s seen %h exp %h", $time, msg, seen, exp);
		end
	endtask : chk

	// A hang counts as a mismatch and closes the run
	task automatic timeout(input string msg);
		error_cnt++;
		$display("BAD t=%0t timeout %s", $time, msg);
		results();
	endtask : timeout

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask : reg_wr

	// Read data stand only in the cycle after the strobe
	task automatic reg_rd(input logic [7:0] a);
		@(posedge clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : reg_rd

	// One sample through the receiver model, then let the loop update land
	task automatic smp(input int ma, input int lag_n);
		int k;
		@(posedge clk);
		send    <= 1'b1;
		send_ma <= 16'(ma);
		lag     <= 4'(lag_n);
		@(posedge clk);
		send <= 1'b0;
		for (k = 0; k < 40; k++) begin
			@(posedge clk);
			#1;
			if (cell_cur_vld === 1'b1)
				break;
		end
		if (k == 40)
			timeout("no sample");
		step(1);
	endtask : smp

	// Measures one full gate period and its high part
	task automatic drive_chk(input int p);
		int   k, per, hi;
		logic prev, go;
		prev = 1'b1;
		go   = 1'b0;
		per  = 0;
		hi   = 0;
		for (k = 0; k < 800; k++) begin
			@(posedge clk);
			#1;
			chk(hb_high & hb_low, 1'b0, "gate overlap");
			if (hb_high && !prev && go)
				break;
			if (hb_high && !prev)
				go = 1'b1;
			per += int'(go);
			hi  += int'(go & hb_high);
			prev = hb_high;
		end
		if (k == 800)
			timeout("no drive");
		chk(per, p, "drive period");
		chk(hi, p / 2, "high phase");
	endtask : drive_chk

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_reset;
		chk(coil_en, 6'h01, "reset cell");
		chk(match_sw_close, 1'b0, "reset switch");
		chk(vin_cmd_mv, 15'h0000, "reset volt");
		chk({hb_high, hb_low}, 2'h0, "reset gates");
		reg_rd(`REG_PERIOD);
		chk(d[7:0], 8'hb5, "reset period");
		reg_wr(8'h20, 32'hffff_ffff);
		reg_rd(8'h20);
		chk(d, 32'h0000_0000, "unmapped");
		$display("test reset done");
	endtask : t_reset

	task automatic t_coils;
		logic [5:0] m [7] = '{6'h05, 6'h00, 6'h15, 6'h0f, 6'h03, 6'h3f, 6'h04};
		logic       ok [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
		logic [5:0] exp;
		exp = 6'h01;
		for (int i = 0; i < 7; i++) begin
			reg_wr(`REG_COIL_REQ, {26'h0, m[i]});
			step(1);
			exp = ok[i] ? m[i] : exp;
			chk(coil_en, exp, "active cell");
			chk(match_sw_close, $countones(exp) > 1, "match switch");
			reg_rd(`REG_COIL_STAT);
			chk({d[8], d[5:0]}, {~ok[i], exp}, "cell status");
			if (!ok[i])
				reg_wr(`REG_COIL_STAT, 32'h0000_0100);
		end
		$display("test coils done");
	endtask : t_coils

	task automatic t_drive;
		reg_wr(`REG_CTRL, 32'h1);
		drive_chk(181);
		reg_wr(`REG_PERIOD, 32'h10);
		reg_rd(`REG_PERIOD);
		chk(d[7:0], 8'd177, "period floor");
		drive_chk(177);
		reg_wr(`REG_PERIOD, 32'hff);
		drive_chk(190);
		reg_wr(`REG_CTRL, 32'h0);
		step(3);
		chk({hb_high, hb_low, vin_cmd_mv}, 17'h0, "stopped");
		$display("test drive done");
	endtask : t_drive

	task automatic t_loop;
		logic [14:0] ceil_v, prev_v;
		reg_wr(`REG_COIL_REQ, 32'h04);
		reg_wr(`REG_TARGET, 32'd1000);
		reg_wr(`REG_CTRL, 32'h1);
		step(1);
		chk(vin_cmd_mv, 15'd12000, "ping volt");
		smp(1500, 0);
		chk(vin_cmd_mv, 15'd12000, "first sample");
		smp(1500, 5);
		chk(vin_cmd_mv, 15'd11500, "p step");
		reg_rd(`REG_MEAS);
		chk(d[15:0], 16'd1500, "measured");
		smp(1001, 0);
		chk(vin_cmd_mv, 15'd11499, "1 mV step");
		smp(5000, 2);
		chk(vin_cmd_mv < 15'd9499, 1'b1, "single coil cap");
		reg_rd(`REG_VOLT);
		ceil_v = d[30:16];
		prev_v = d[14:0];
		chk(ceil_v < 15'd20000 && prev_v <= ceil_v, 1'b1, "ceiling");
		chk(d[30:0], {15'd8499, 1'b0, 15'd8499}, "ceiling value");
		smp(0, 1);
		chk(vin_cmd_mv, (prev_v + 15'd1000 > ceil_v) ? ceil_v : prev_v + 15'd1000, "rise to ceiling");
		reg_wr(`REG_COIL_REQ, 32'h15);
		reg_wr(`REG_TARGET, 32'd60000);
		for (int i = 0; i < 8; i++)
			smp(0, i % 3);
		chk(vin_cmd_mv, 15'd20000, "top volt");
		reg_wr(`REG_TARGET, 32'd1000);
		smp(4000, 0);
		chk(vin_cmd_mv, 15'd18000, "4 A edge");
		for (int i = 0; i < 10; i++)
			smp(4000, i % 2);
		chk(vin_cmd_mv, 15'd0, "floor volt");
		smp(0, 0);
		reg_wr(`REG_CTRL, 32'h0);
		step(1);
		chk(vin_cmd_mv, 15'd0, "off volt");
		$display("test loop done");
	endtask : t_loop

	// Reset in mid-run, with power on and a three coil cell
	task automatic t_rerst;
		reg_wr(`REG_COIL_REQ, 32'h15);
		reg_wr(`REG_PERIOD, 32'hb0);
		reg_wr(`REG_CTRL, 32'h1);
		step(2);
		@(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		step(1);
		chk(coil_en, 6'h01, "rerst cell");
		chk(match_sw_close, 1'b0, "rerst switch");
		chk(vin_cmd_mv, 15'h0000, "rerst volt");
		chk({hb_high, hb_low}, 2'h0, "rerst gates");
		reg_rd(`REG_PERIOD);
		chk(d[7:0], 8'hb5, "rerst period");
		$display("test rerst done");
	endtask : t_rerst

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		srst       = 1'b1;
		wr         = 1'b0;
		rd         = 1'b0;
		send       = 1'b0;
		addr       = 8'h00;
		wdata      = 32'h0;
		send_ma    = 16'h0;
		lag        = 4'h0;
		error_cnt  = 0;
		num_checks = 0;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		step(1);
		t_reset();
		t_coils();
		t_drive();
		t_loop();
		t_rerst();
		results();
	end
endmodule : testbench
`default_nettype wire
